// ===== bench/tb_top.sv
// self-checking testbench for the performance monitor counter bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import pmn_pkg::*;
	logic                  mclk               = 1'b0;
	logic                  rst_b              = 1'b0;
	logic                  ce                 = 1'b1;
	logic                  accum_trigger      = 1'b0;
	logic [3:0]            evt                = 4'h0;
	logic                  reg_req            = 1'b0;
	logic                  reg_wr             = 1'b0;
	logic [PMN_ADDR_W-1:0] reg_addr           = 12'h000;
	logic [PMN_DATA_W-1:0] reg_wdata          = 32'h0000_0000;
	logic [3:0]            byte_lane_select_n = 4'hF;
	logic [PMN_DATA_W-1:0] reg_rdata;
	logic                  reg_rvalid;
	int                    n_mismatch         = 0;
	int                    tests_run          = 0;
	// ------------------------------------------------------------
	// clock, design
	// ------------------------------------------------------------
	initial begin
		forever #2 mclk = ~mclk;
	end
	pmn_perf_monitor i_dut (
		.mclk               (mclk),
		.rst_b              (rst_b),
		.ce                 (ce),
		.accum_trigger      (accum_trigger),
		.rx_overflow_evt    (evt[0]),
		.tx_underflow_evt   (evt[1]),
		.select_event1_evt  (evt[2]),
		.select_event2_evt  (evt[3]),
		.reg_req            (reg_req),
		.reg_wr             (reg_wr),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.byte_lane_select_n (byte_lane_select_n),
		.reg_rdata          (reg_rdata),
		.reg_rvalid         (reg_rvalid)
	);
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// read; want is low where no answer may come
	task automatic rd(input logic [11:0] a, input logic [3:0] ln, input logic [31:0] exp, input bit want);
		bit got;
		got = 1'b0;
		@(posedge mclk);
		reg_req            <= 1'b1;
		reg_wr             <= 1'b0;
		reg_addr           <= a;
		byte_lane_select_n <= ln;
		@(posedge mclk);
		reg_req <= 1'b0;
		for (int i = 0; i < 4 && !got; i++) begin
			#1;
			if (reg_rvalid === 1'b1) got = 1'b1;
			else @(posedge mclk);
		end
		chk($sformatf("rvalid %h", a), {31'h0, want}, {31'h0, got});
		if (got) chk($sformatf("rdata %h", a), exp, reg_rdata);
		if (want && !got) tally_and_finish();
	endtask : rd
	task automatic wr(input logic [11:0] a, input logic [3:0] ln, input logic [31:0] d);
		@(posedge mclk);
		reg_req            <= 1'b1;
		reg_wr             <= 1'b1;
		reg_addr           <= a;
		reg_wdata          <= d;
		byte_lane_select_n <= ln;
		@(posedge mclk);
		reg_req <= 1'b0;
		reg_wr  <= 1'b0;
	endtask : wr
	// events in bit order rx, tx, sel1, sel2, held n cycles
	task automatic ev(input logic [3:0] e, input logic t, input int n);
		repeat (n) begin
			@(posedge mclk);
			evt           <= e;
			accum_trigger <= t;
		end
		@(posedge mclk);
		evt           <= 4'h0;
		accum_trigger <= 1'b0;
	endtask : ev
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		rd(12'h500, 4'h0, 32'h0000_0000, 1'b1);
		rd(12'h504, 4'h0, 32'h0000_0000, 1'b1);
		ev(4'b1101, 1'b0, 1);
		ev(4'b0101, 1'b0, 2);
		ev(4'b0100, 1'b0, 2);
		ev(4'b0000, 1'b1, 1);
		rd(12'h500, 4'h0, 32'h0000_0034, 1'b1);
		rd(12'h504, 4'h0, 32'h0000_0003, 1'b1);
		rd(12'h508, 4'h0, 32'h0000_0000, 1'b1);
		rd(12'h50C, 4'h0, 32'h0000_0005, 1'b1);
		rd(12'h510, 4'h0, 32'h0000_0001, 1'b1);
		wr(12'h504, 4'h0, 32'hFFFF_FFFF);
		wr(12'h504, 4'hE, 32'h0000_0000);
		rd(12'h504, 4'hE, 32'h0000_0003, 1'b1);
		rd(12'h50C, 4'h7, 32'h0000_0005, 1'b1);
		rd(12'h504, 4'hF, 32'h0000_0000, 1'b0);
		rd(12'h514, 4'h0, 32'h0000_0000, 1'b1);
		// sel2 event on the trigger edge belongs to the new interval
		ev(4'b1000, 1'b1, 1);
		rd(12'h500, 4'h0, 32'h0000_0000, 1'b1);
		rd(12'h510, 4'h0, 32'h0000_0000, 1'b1);
		ev(4'b0000, 1'b1, 1);
		rd(12'h500, 4'h0, 32'h0000_0020, 1'b1);
		rd(12'h510, 4'h0, 32'h0000_0001, 1'b1);
		ev(4'b0000, 1'b1, 2);
		rd(12'h500, 4'h0, 32'h0000_0000, 1'b1);
		// two past full scale on every counter
		ev(4'b1111, 1'b0, 65537);
		ev(4'b0000, 1'b1, 1);
		rd(12'h504, 4'h0, 32'h0000_FFFF, 1'b1);
		rd(12'h508, 4'h0, 32'h0000_FFFF, 1'b1);
		rd(12'h50C, 4'h0, 32'h0000_FFFF, 1'b1);
		rd(12'h510, 4'h0, 32'h0000_FFFF, 1'b1);
		rd(12'h500, 4'h0, 32'h0000_003C, 1'b1);
		// clock enable low: events and trigger are both ignored
		@(posedge mclk);
		ce <= 1'b0;
		ev(4'b1111, 1'b1, 2);
		ce <= 1'b1;
		rd(12'h504, 4'h0, 32'h0000_FFFF, 1'b1);
		ev(4'b0000, 1'b1, 1);
		rd(12'h50C, 4'h0, 32'h0000_0000, 1'b1);
		// reset in mid-run clears tallies, flags and running counts
		ev(4'b1111, 1'b0, 3);
		ev(4'b0000, 1'b1, 1);
		rd(12'h508, 4'h0, 32'h0000_0003, 1'b1);
		ev(4'b1111, 1'b0, 2);
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		rd(12'h500, 4'h0, 32'h0000_0000, 1'b1);
		rd(12'h508, 4'h0, 32'h0000_0000, 1'b1);
		ev(4'b0000, 1'b1, 1);
		rd(12'h510, 4'h0, 32'h0000_0000, 1'b1);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire

// ===== rtl/pmn_cnt_if.sv
// signals between the register front end and one event counter
`timescale 1ns/1ns
`default_nettype none
interface pmn_cnt_if;
	import pmn_pkg::*;
	logic                 trig;   // accumulation trigger pulse
	logic                 evt;    // event pulse
	logic [PMN_CNT_W-1:0] count;  // running count of current interval
	logic [PMN_CNT_W-1:0] tally;  // holding value of previous interval
	logic                 seen;   // holding value is non-zero
	modport cnt (input trig, input evt, output count, output tally, output seen);
	modport ctl (output trig, output evt, input count, input tally, input seen);
endinterface : pmn_cnt_if
`default_nettype wire

// ===== rtl/pmn_counter.sv
// one saturating event counter with holding register and detect flag
`timescale 1ns/1ns
`default_nettype none
module pmn_counter
	import pmn_pkg::*;
(
	input  wire logic mclk,     // system clock
	input  wire logic rst_b,    // synchronous reset, active low
	input  wire logic ce,       // clock enable
	pmn_cnt_if.cnt    port_c    // trigger, event and results
);
	logic [PMN_CNT_W-1:0] count_r;
	logic [PMN_CNT_W-1:0] count_nxt;
	logic [PMN_CNT_W-1:0] tally_r;
	logic                 seen_r;

	// ------------------------------------------------------------
	// running count
	// ------------------------------------------------------------
	always_comb begin
		if (port_c.trig) begin
			// an event in the trigger cycle opens the new interval
			count_nxt = port_c.evt ? PMN_CNT_W'(1) : PMN_CNT_RST;
		end else if (port_c.evt && count_r != PMN_CNT_SAT) begin
			count_nxt = count_r + PMN_CNT_W'(1);
		end else begin
			count_nxt = count_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			count_r <= PMN_CNT_RST;
		end else if (ce) begin
			count_r <= count_nxt;
		end
	end

	// ------------------------------------------------------------
	// holding register and detect flag
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tally_r <= PMN_CNT_RST;
			seen_r  <= 1'b0;
		end else if (ce && port_c.trig) begin
			tally_r <= count_r;
			seen_r  <= (count_r != PMN_CNT_RST);
		end
	end

	assign port_c.count = count_r;
	assign port_c.tally = tally_r;
	assign port_c.seen  = seen_r;
endmodule : pmn_counter
`default_nettype wire

// ===== rtl/pmn_perf_monitor.sv
// performance monitor: four event counters behind a 32-bit register port
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module pmn_perf_monitor
	import pmn_pkg::*;
(
	input  wire logic                  mclk,               // system clock, 250 MHz
	input  wire logic                  rst_b,              // synchronous reset, active low
	input  wire logic                  ce,                 // clock enable, freezes all state when low
	input  wire logic                  accum_trigger,      // one-cycle pulse: trigger register written
	input  wire logic                  rx_overflow_evt,    // one-cycle receive overflow event
	input  wire logic                  tx_underflow_evt,   // one-cycle transmit underflow event
	input  wire logic                  select_event1_evt,  // one-cycle selected event, counter one
	input  wire logic                  select_event2_evt,  // one-cycle selected event, counter two
	input  wire logic                  reg_req,            // register access request
	input  wire logic                  reg_wr,             // high for write, low for read
	input  wire logic [PMN_ADDR_W-1:0] reg_addr,           // byte address
	input  wire logic [PMN_DATA_W-1:0] reg_wdata,          // write data, ignored by read-only map
	input  wire logic [3:0]            byte_lane_select_n, // byte enables, active low
	output logic      [PMN_DATA_W-1:0] reg_rdata,          // read data, registered
	output logic                       reg_rvalid          // one-cycle read answer
);
	// ------------------------------------------------------------
	// counter bank
	// ------------------------------------------------------------
	pmn_cnt_if cnt_if [PMN_NUM_CNT] ();

	logic [PMN_NUM_CNT-1:0] evt_vec;
	logic [PMN_CNT_W-1:0]   tally_w [PMN_NUM_CNT];
	logic [PMN_CNT_W-1:0]   count_w [PMN_NUM_CNT];
	logic [PMN_NUM_CNT-1:0] seen_w;

	assign evt_vec[PMN_IDX_RXOVF] = rx_overflow_evt;
	assign evt_vec[PMN_IDX_TXUNF] = tx_underflow_evt;
	assign evt_vec[PMN_IDX_SEL1]  = select_event1_evt;
	assign evt_vec[PMN_IDX_SEL2]  = select_event2_evt;

	for (genvar gi = 0; gi < PMN_NUM_CNT; gi++) begin : g_cnt
		assign cnt_if[gi].trig = accum_trigger;
		assign cnt_if[gi].evt  = evt_vec[gi];
		assign tally_w[gi]     = cnt_if[gi].tally;
		assign count_w[gi]     = cnt_if[gi].count;
		assign seen_w[gi]      = cnt_if[gi].seen;
		pmn_counter u_cnt (
			.mclk   (mclk),
			.rst_b  (rst_b),
			.ce     (ce),
			.port_c (cnt_if[gi])
		);
	end

	// ------------------------------------------------------------
	// register read decode
	// ------------------------------------------------------------
	logic                  acc_ok;
	logic [PMN_ADDR_W-1:0] word_addr;
	logic [PMN_DATA_W-1:0] rd_mux;
	logic [PMN_DATA_W-1:0] reg_rdata_r;
	logic                  reg_rvalid_r;

	// any lane pattern other than all-off is a full-word access
	assign acc_ok    = reg_req && (byte_lane_select_n != PMN_BE_NONE_N);
	assign word_addr = {reg_addr[PMN_ADDR_W-1:2], 2'b00};

	always_comb begin
		rd_mux = PMN_RD_RST;
		unique case (word_addr)
			PMN_STATUS_OFS: rd_mux[PMN_SEEN_LSB +: PMN_NUM_CNT] = seen_w;
			PMN_RXOVF_OFS:  rd_mux[PMN_CNT_W-1:0] = tally_w[PMN_IDX_RXOVF];
			PMN_TXUNF_OFS:  rd_mux[PMN_CNT_W-1:0] = tally_w[PMN_IDX_TXUNF];
			PMN_SEL1_OFS:   rd_mux[PMN_CNT_W-1:0] = tally_w[PMN_IDX_SEL1];
			PMN_SEL2_OFS:   rd_mux[PMN_CNT_W-1:0] = tally_w[PMN_IDX_SEL2];
			default:        rd_mux = PMN_RD_RST;
		endcase
	end

	// ------------------------------------------------------------
	// read answer; writes to this read-only map have no effect
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			reg_rdata_r  <= PMN_RD_RST;
			reg_rvalid_r <= 1'b0;
		end else if (ce) begin
			reg_rvalid_r <= acc_ok && !reg_wr;
			if (acc_ok && !reg_wr) begin
				reg_rdata_r <= rd_mux;
			end
		end
	end

	assign reg_rdata  = reg_rdata_r;
	assign reg_rvalid = reg_rvalid_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_seen_two: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && accum_trigger |=> seen_w[PMN_IDX_SEL2] == ($past(count_w[PMN_IDX_SEL2]) != PMN_CNT_RST))
		else $error("second selectable detect flag does not follow its tally");

	a_rd_status: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && acc_ok && !reg_wr && word_addr == PMN_STATUS_OFS
		|=> reg_rvalid && reg_rdata == {26'h000_0000, $past(seen_w), 2'b00})
		else $error("status read returned wrong flags");

	a_rd_rxovf: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && acc_ok && !reg_wr && word_addr == PMN_RXOVF_OFS
		|=> reg_rdata == {16'h0000, $past(tally_w[PMN_IDX_RXOVF])})
		else $error("receive overflow tally read wrong");

	a_rd_txunf: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && acc_ok && !reg_wr && word_addr == PMN_TXUNF_OFS
		|=> reg_rdata == {16'h0000, $past(tally_w[PMN_IDX_TXUNF])})
		else $error("transmit underflow tally read wrong");

	a_rd_sel1: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && acc_ok && !reg_wr && word_addr == PMN_SEL1_OFS
		|=> reg_rdata == {16'h0000, $past(tally_w[PMN_IDX_SEL1])})
		else $error("first selectable tally read wrong");

	a_rd_sel2: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && acc_ok && !reg_wr && word_addr == PMN_SEL2_OFS
		|=> reg_rdata == {16'h0000, $past(tally_w[PMN_IDX_SEL2])})
		else $error("second selectable tally read wrong");

	a_trig_snap: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && accum_trigger && !rx_overflow_evt
		|=> count_w[PMN_IDX_RXOVF] == PMN_CNT_RST && tally_w[PMN_IDX_RXOVF] == $past(count_w[PMN_IDX_RXOVF]))
		else $error("trigger did not snapshot and clear the count");

	a_trig_evt: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && accum_trigger && tx_underflow_evt |=> count_w[PMN_IDX_TXUNF] == 16'h0001)
		else $error("event in trigger cycle was lost");

	a_part_lane: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && reg_req && !reg_wr && byte_lane_select_n != PMN_BE_NONE_N |=> reg_rvalid)
		else $error("partial lane read was not answered as a full word");

	a_no_lane: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && reg_req && byte_lane_select_n == PMN_BE_NONE_N |=> !reg_rvalid)
		else $error("access with all lanes off was answered");

	a_sat_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && !accum_trigger && count_w[PMN_IDX_SEL1] == PMN_CNT_SAT
		|=> count_w[PMN_IDX_SEL1] == PMN_CNT_SAT)
		else $error("counter wrapped past all ones");

	a_ce_freeze: assert property (@(posedge mclk) disable iff (!rst_b)
		!ce |=> $stable(reg_rdata) && $stable(reg_rvalid) && $stable(tally_w[PMN_IDX_SEL2]))
		else $error("state moved while clock enable was low");

	a_ce_count: assert property (@(posedge mclk) disable iff (!rst_b)
		!ce
		|=> $stable(count_w[PMN_IDX_RXOVF]) && $stable(seen_w))
		else $error("count or flags moved while clock enable was low");

	a_seen_rx: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && accum_trigger
		|=> seen_w[PMN_IDX_RXOVF] == ($past(count_w[PMN_IDX_RXOVF]) != PMN_CNT_RST))
		else $error("overflow detect flag does not follow its tally");

	a_seen_tx: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && accum_trigger
		|=> seen_w[PMN_IDX_TXUNF] == ($past(count_w[PMN_IDX_TXUNF]) != PMN_CNT_RST))
		else $error("underflow detect flag does not follow its tally");

	a_seen_sel1: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && accum_trigger
		|=> seen_w[PMN_IDX_SEL1] == ($past(count_w[PMN_IDX_SEL1]) != PMN_CNT_RST))
		else $error("first selectable detect flag does not follow its tally");

	a_snap_tx: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && accum_trigger
		|=> tally_w[PMN_IDX_TXUNF] == $past(count_w[PMN_IDX_TXUNF]))
		else $error("trigger did not snapshot the underflow count");

	a_snap_sel1: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && accum_trigger
		|=> tally_w[PMN_IDX_SEL1] == $past(count_w[PMN_IDX_SEL1]))
		else $error("trigger did not snapshot the first selectable count");

	a_snap_sel2: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && accum_trigger
		|=> tally_w[PMN_IDX_SEL2] == $past(count_w[PMN_IDX_SEL2]))
		else $error("trigger did not snapshot the second selectable count");

	a_clr_sel2: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && accum_trigger && !select_event2_evt
		|=> count_w[PMN_IDX_SEL2] == PMN_CNT_RST)
		else $error("trigger did not clear the second selectable count");

	a_tally_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && !accum_trigger
		|=> $stable(tally_w[PMN_IDX_RXOVF]) && $stable(seen_w))
		else $error("holding register moved without a trigger");

	a_cnt_step: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && !accum_trigger && rx_overflow_evt && count_w[PMN_IDX_RXOVF] != PMN_CNT_SAT
		|=> count_w[PMN_IDX_RXOVF] == $past(count_w[PMN_IDX_RXOVF]) + PMN_CNT_W'(1))
		else $error("overflow event was not counted");

	a_cnt_idle: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && !accum_trigger && !rx_overflow_evt
		|=> $stable(count_w[PMN_IDX_RXOVF]))
		else $error("overflow count moved without an event");

	a_sat_reach: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && !accum_trigger && select_event1_evt && count_w[PMN_IDX_SEL1] == PMN_CNT_SAT - PMN_CNT_W'(1)
		|=> count_w[PMN_IDX_SEL1] == PMN_CNT_SAT)
		else $error("counter did not reach all ones");

	a_wr_silent: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && acc_ok && reg_wr
		|=> !reg_rvalid && $stable(reg_rdata))
		else $error("write to the read-only map changed the read port");

	a_no_lane_data: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && reg_req && byte_lane_select_n == PMN_BE_NONE_N
		|=> $stable(reg_rdata))
		else $error("access with all lanes off changed the read data");

	a_rv_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
		ce && !(acc_ok && !reg_wr)
		|=> !reg_rvalid)
		else $error("read answer without a read request");
endmodule : pmn_perf_monitor
`default_nettype wire

// ===== rtl/pmn_pkg.sv
// constants for the performance monitor counter bank
package pmn_pkg;
	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int          PMN_CNT_W     = 16;
	localparam int          PMN_ADDR_W    = 12;
	localparam int          PMN_DATA_W    = 32;
	localparam int          PMN_NUM_CNT   = 4;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] PMN_STATUS_OFS = 12'h0500;
	localparam logic [11:0] PMN_RXOVF_OFS  = 12'h0504;
	localparam logic [11:0] PMN_TXUNF_OFS  = 12'h0508;
	localparam logic [11:0] PMN_SEL1_OFS   = 12'h050C;
	localparam logic [11:0] PMN_SEL2_OFS   = 12'h0510;
	// ------------------------------------------------------------
	// counter indices and status bit positions
	// ------------------------------------------------------------
	localparam int          PMN_IDX_RXOVF  = 0;
	localparam int          PMN_IDX_TXUNF  = 1;
	localparam int          PMN_IDX_SEL1   = 2;
	localparam int          PMN_IDX_SEL2   = 3;
	localparam int          PMN_SEEN_LSB   = 2;
	// ------------------------------------------------------------
	// values
	// ------------------------------------------------------------
	localparam logic [15:0] PMN_CNT_SAT    = 16'hFFFF;
	localparam logic [15:0] PMN_CNT_RST    = 16'h0000;
	localparam logic [31:0] PMN_RD_RST     = 32'h0000_0000;
	localparam logic [3:0]  PMN_BE_NONE_N  = 4'hF;
endpackage : pmn_pkg
